// File: hicc_controller.sv
// Host interface command controller: decodes host accesses and paces the host.
`timescale 1ns/10ps

// How it works
// RULE1: Bits 17:16 zero select memory word access.
// RULE2: Access stops CPU, swaps bus drivers over.
// RULE3: Host write-enable picks read or write.
// RULE4: Code 01 accesses diagnostic port register.
// RULE5: Code 10 low bits pick run controls.
// RULE6: Code 11 low bits pick chain operations.
// RULE7: Host never issues illegal low code zero.
// RULE8: Halt stops clocks until run; steps override.
// RULE9: Run lets system clocks free run.
// RULE10: Step all pulses every clock once.
// RULE11: Control step clocks control registers only.
// RULE12: Data step clocks data section only.
// RULE13: Interrupt command raises interrupt request input.
// RULE14: Reset asserts reset, pulses ungated clocks.
// RULE15: Load pipeline pulses pipe clocks, parallel load.
// RULE16: Load macro pulses macro group, parallel load.
// RULE17: Load store runs write sequence from chain.
// RULE18: Load init loads store initialise registers.
// RULE19: Capture copies pipeline registers into chain.
// RULE20: Store shift swaps port and store chain.
// RULE21: Macro shift swaps port and macro chain.
// RULE22: Store shifting keeps system clocks halted.
// RULE23: Ready low until done, high until deselect.
// RULE24: Shift commands carry nibble count.
// RULE25: Host signals pass a synchronising register.
// RULE26: Deselect returns buses and clocks to CPU.
module hicc_controller
    import hicc_pkg::*;
(
    input wire logic sys_clk,                          // System clock, 10 MHz.
    input wire logic reset_n,                          // Synchronous reset, active low.
    input wire logic hostSelect,                       // Host selects the system, async.
    input wire logic [HOST_ADDR_W-1:0] hostAddr,       // Host address, async.
    input wire logic hostWriteEn,                      // Host write enable, async.
    input wire logic storeChainOut,                    // Serial bit leaving store chain.
    input wire logic macroChainOut,                    // Serial bit leaving macro chain.
    output logic host_wait_release,                    // Ready to host, high when done.
    output logic [MEM_ADDR_W-1:0] memory_address_bus,  // Word address towards memory.
    output logic memWrite,                             // Memory write strobe.
    output logic memRead,                              // Memory read enable.
    output logic portWrite,                            // Port register write from data bus.
    output logic portRead,                             // Port register read onto data bus.
    output logic extXcvrEn,                            // External transceivers on buses.
    output logic cpuDriveEn,                           // CPU drivers on buses.
    output logic cpuRun,                               // Free running CPU clocks enabled.
    output hicc_clk_t clkPulse,                        // One cycle clock group pulses.
    output hicc_scan_t shadow_scan_chain,              // Shadow chain controls.
    output logic [PORT_W-1:0] portShiftData,           // Port register image while shifting.
    output logic portShiftLoad,                        // Port register takes portShiftData.
    output logic chainSerialIn,                        // Serial bit into selected chain.
    output logic cpuIrqReq,                            // Interrupt request, one cycle.
    output logic cpuReset                              // CPU reset line.
);

    // ------------------------------------------------------------------
    // Host synchronisers
    // ------------------------------------------------------------------
    logic [HOST_ADDR_W+1:0] syncA;
    logic [HOST_ADDR_W+1:0] syncB;
    logic selS;
    logic weS;
    logic [HOST_ADDR_W-1:0] addrS;

    // Two flops for every host signal; only the second stage is used.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            syncA <= '0;
            syncB <= '0;
        end else begin
            syncA <= {hostSelect, hostWriteEn, hostAddr}; // [RULE25]
            syncB <= syncA;
        end
    end
    assign selS = syncB[HOST_ADDR_W+1];
    assign weS = syncB[HOST_ADDR_W];
    assign addrS = syncB[HOST_ADDR_W-1:0];

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    hicc_state_t state;
    logic [1:0] space;
    logic [2:0] op;
    logic writeDir;
    logic [3:0] cnt;
    logic [6:0] bitsLeft;
    logic halted;
    logic shiftMacro;

    assign space = addrS[SEL_HI_BIT:SEL_LO_BIT];
    assign op = addrS[2:0];

    // Command state, latched write direction, and counters.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            writeDir <= 1'b0;
            cnt <= 4'h0;
            bitsLeft <= 7'h00;
            shiftMacro <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (selS) begin
                        state <= ST_DECODE;
                    end
                end
                ST_DECODE: begin
                    writeDir <= weS; // [RULE3]
                    cnt <= ACCESS_CNT;
                    shiftMacro <= (op == OP_SHIFT_MACRO);
                    // A zero count means sixteen nibbles, the longest shift the field allows.
                    bitsLeft <= {(addrS[NIB_CNT_LSB+:NIB_CNT_W] == 4'h0),
                                 addrS[NIB_CNT_LSB+:NIB_CNT_W], 2'h0}; // [RULE24]
                    if (!space[1]) begin
                        state <= ST_ACCESS; // [RULE1] [RULE4]
                    end else if (op == OP_ILLEGAL) begin
                        state <= ST_TRAP; // [RULE7]
                    end else if (space == SPACE_SCAN &&
                                 (op == OP_SHIFT_STORE || op == OP_SHIFT_MACRO)) begin
                        state <= ST_SHIFT;
                    end else begin
                        state <= ST_PULSE;
                        if (space == SPACE_SCAN && op == OP_LOAD_STORE) begin
                            cnt <= STORE_WRITE_CNT; // [RULE17]
                        end else begin
                            cnt <= 4'h1;
                        end
                    end
                end
                ST_ACCESS, ST_PULSE: begin
                    if (cnt <= 4'h1) begin
                        state <= ST_DONE;
                    end
                    cnt <= cnt - 4'h1;
                end
                ST_SHIFT: begin
                    bitsLeft <= bitsLeft - 7'h01;
                    if (bitsLeft == 7'h01) begin
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    if (!selS) begin
                        state <= ST_IDLE; // [RULE23]
                    end
                end
                ST_TRAP: begin
                    state <= ST_TRAP; // Only reset leaves this state.
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Halt mode: set by halt, cleared by run; steps leave it set.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            halted <= 1'b0;
        end else if (state == ST_PULSE && space == SPACE_RUNCTL && cnt == 4'h1) begin
            if (op == OP_HALT) begin
                halted <= 1'b1; // [RULE8]
            end else if (op == OP_RUN) begin
                halted <= 1'b0; // [RULE9]
            end
        end
    end

    // ------------------------------------------------------------------
    // Bus ownership, memory and port strobes
    // ------------------------------------------------------------------
    logic busy;
    assign busy = (state != ST_IDLE);

    // Host owns the buses from decode to idle, except in the cycle after decoding a run-control or scan command; the CPU gets them back
    // at idle, and its clocks restart only when no halt is in force.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            extXcvrEn <= 1'b0;
            cpuDriveEn <= 1'b1;
            cpuRun <= 1'b1;
            host_wait_release <= 1'b0;
        end else begin
            extXcvrEn <= busy && (state != ST_DECODE || !space[1]); // [RULE2] [RULE26]
            cpuDriveEn <= !busy; // [RULE2] [RULE26]
            cpuRun <= !busy && !halted; // [RULE2] [RULE8] [RULE22] [RULE26]
            host_wait_release <= (state == ST_DONE) && selS; // [RULE23]
        end
    end

    // Memory or port strobes during the access window.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            memory_address_bus <= '0;
            memWrite <= 1'b0;
            memRead <= 1'b0;
            portWrite <= 1'b0;
            portRead <= 1'b0;
        end else begin
            memory_address_bus <= addrS[MEM_ADDR_W-1:0]; // [RULE1]
            memRead <= state == ST_ACCESS && space == SPACE_MEM && !writeDir; // [RULE3]
            memWrite <= state == ST_ACCESS && space == SPACE_MEM && writeDir && cnt == 4'h1;
            portRead <= state == ST_ACCESS && space == SPACE_PORT && !writeDir; // [RULE4]
            portWrite <= state == ST_ACCESS && space == SPACE_PORT && writeDir && cnt == 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Command pulses
    // ------------------------------------------------------------------
    logic runPulse;
    logic scanPulse;
    assign runPulse = (state == ST_PULSE) && (space == SPACE_RUNCTL); // [RULE5]
    assign scanPulse = (state == ST_PULSE) && (space == SPACE_SCAN); // [RULE6]

    // Clock group pulses and run-control side effects, one cycle each.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            clkPulse <= '0;
            cpuIrqReq <= 1'b0;
            cpuReset <= 1'b0;
        end else begin
            clkPulse.ctrlPipe <= (runPulse && (op == OP_STEP_ALL || op == OP_STEP_CTRL ||
                                  op == OP_RESET)) || (scanPulse && op == OP_LOAD_PIPE);
            clkPulse.macro <= (runPulse && (op == OP_STEP_ALL || op == OP_STEP_CTRL ||
                               op == OP_RESET)) || (scanPulse && op == OP_LOAD_MACRO);
            clkPulse.sequencer <= runPulse && (op == OP_STEP_ALL ||
                                  op == OP_STEP_CTRL || op == OP_RESET); // [RULE11]
            clkPulse.dataSect <= runPulse && (op == OP_STEP_ALL ||
                                 op == OP_STEP_DATA || op == OP_RESET); // [RULE10] [RULE12]
            clkPulse.gatedOk <= runPulse && op == OP_STEP_ALL; // [RULE10] [RULE14]
            cpuIrqReq <= runPulse && op == OP_INTERRUPT; // [RULE13]
            cpuReset <= runPulse && op == OP_RESET; // [RULE14]
        end
    end

    // Shadow chain controls; the pipeline groups above pulse with the load.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            shadow_scan_chain <= '0;
        end else begin
            shadow_scan_chain.parallelLoad <= scanPulse &&
                (op == OP_LOAD_PIPE || op == OP_LOAD_MACRO); // [RULE15] [RULE16]
            shadow_scan_chain.storeWrite <= scanPulse && op == OP_LOAD_STORE; // [RULE17]
            shadow_scan_chain.initLoad <= scanPulse && op == OP_LOAD_INIT; // [RULE18]
            shadow_scan_chain.capture <= scanPulse && op == OP_CAPTURE; // [RULE19]
            shadow_scan_chain.storeShift <= state == ST_SHIFT && !shiftMacro; // [RULE20]
            shadow_scan_chain.macroShift <= state == ST_SHIFT && shiftMacro; // [RULE21]
        end
    end

    // ------------------------------------------------------------------
    // Serial exchange with the port register
    // ------------------------------------------------------------------
    logic [PORT_W-1:0] shiftImage;
    logic returnBit;
    assign returnBit = shiftMacro ? macroChainOut : storeChainOut;

    // Port image rotates one bit per shift: low bit out, chain end in on top.
    // The image starts cleared and is not reloaded from the data bus.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            shiftImage <= '0;
            portShiftData <= '0;
            portShiftLoad <= 1'b0;
            chainSerialIn <= 1'b0;
        end else begin
            portShiftLoad <= (state == ST_SHIFT); // [RULE20] [RULE21]
            if (state == ST_SHIFT) begin
                chainSerialIn <= shiftImage[0];
                shiftImage <= {returnBit, shiftImage[PORT_W-1:1]};
                portShiftData <= {returnBit, shiftImage[PORT_W-1:1]};
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_done_wait;
        state == ST_DONE && selS;
    endsequence

    chk_ready_until_done: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE23]
        (state == ST_PULSE || state == ST_ACCESS) |=> !host_wait_release)
        else $error("ready raised before command finished");
    chk_ready_drop: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE23]
        s_done_wait ##1 !selS |=> !host_wait_release)
        else $error("ready held after deselect");
    chk_cpu_stopped: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE2]
        busy |=> !cpuRun && !cpuDriveEn)
        else $error("cpu not suspended during host access");
    chk_shift_halts: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE22]
        shadow_scan_chain.storeShift |-> !cpuRun && !clkPulse.ctrlPipe)
        else $error("system clock active during store shift");
    chk_halt_holds: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE8]
        halted && !busy |=> !cpuRun || !halted)
        else $error("clocks run while halted");
    chk_ctrl_step: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE11]
        runPulse && op == OP_STEP_CTRL |=> clkPulse.sequencer && !clkPulse.dataSect)
        else $error("control step touched data section");
    chk_data_step: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE12]
        runPulse && op == OP_STEP_DATA |=> clkPulse.dataSect && !clkPulse.ctrlPipe)
        else $error("data step touched control section");
    chk_reset_pulse: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE14]
        $rose(cpuReset) |-> clkPulse.dataSect && clkPulse.ctrlPipe ##1 !cpuReset)
        else $error("reset without ungated clocks");
    chk_store_len: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE17]
        $rose(shadow_scan_chain.storeWrite) |-> shadow_scan_chain.storeWrite [*3] ##1
        !shadow_scan_chain.storeWrite)
        else $error("store write sequence wrong length");
    chk_xcvr_off: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE26]
        state == ST_IDLE |=> !extXcvrEn && cpuDriveEn)
        else $error("buses not returned to cpu");

endmodule : hicc_controller

// File: hicc_controller_test.sv
// Self-checking testbench of the host command controller.
`timescale 1ns/10ps
module hicc_controller_test
    import hicc_pkg::*;
;
    typedef struct packed {
        logic [15:0] addr;
        logic rd, wr, prd, pwr;
        hicc_clk_t clk;
        logic [4:0] clkMask;
        logic [7:0] pulses;
        hicc_scan_t scan;
        logic [7:0] shifts;
        logic [7:0] loads;
        logic irq, rst, runAfter;
    } hicc_note_t;

    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic hostSelect, hostWriteEn, lastS, lastM, storeChainOut = 1'b0, macroChainOut = 1'b0;
    logic [HOST_ADDR_W-1:0] hostAddr;
    logic host_wait_release, memWrite, memRead, portWrite, portRead, extXcvrEn, cpuDriveEn;
    logic cpuRun, portShiftLoad, chainSerialIn, cpuIrqReq, cpuReset, readyPrev, postChk = 1'b0;
    logic [MEM_ADDR_W-1:0] memory_address_bus;
    logic [PORT_W-1:0] portShiftData;
    logic [PORT_W-1:0] img = '0;
    hicc_clk_t clkPulse;
    hicc_scan_t shadow_scan_chain;
    hicc_note_t noteQ[$];
    hicc_note_t acc = '0, exp;
    logic [31:0] seed = 32'hC168;
    int miscompares = 0, checks = 0;

    always #50 sys_clk = ~sys_clk;

    hicc_controller dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .hostSelect(hostSelect),
        .hostAddr(hostAddr), .hostWriteEn(hostWriteEn), .storeChainOut(storeChainOut),
        .macroChainOut(macroChainOut), .host_wait_release(host_wait_release),
        .memory_address_bus(memory_address_bus), .memWrite(memWrite), .memRead(memRead),
        .portWrite(portWrite), .portRead(portRead), .extXcvrEn(extXcvrEn),
        .cpuDriveEn(cpuDriveEn), .cpuRun(cpuRun), .clkPulse(clkPulse),
        .shadow_scan_chain(shadow_scan_chain), .portShiftData(portShiftData),
        .portShiftLoad(portShiftLoad), .chainSerialIn(chainSerialIn), .cpuIrqReq(cpuIrqReq),
        .cpuReset(cpuReset));

    hicc_host_model hostU (.sys_clk(sys_clk), .hostReady(host_wait_release),
        .hostSelect(hostSelect), .hostAddr(hostAddr), .hostWriteEn(hostWriteEn));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic check(input string what, input logic [63:0] e, input logic [63:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : check

    function automatic hicc_note_t mk(input logic [4:0] c, input logic [4:0] m,
        input logic [7:0] p, input logic [5:0] s, input logic [2:0] ir);
        hicc_note_t n;
        n = '0;
        n.clk = c;
        n.clkMask = m;
        n.pulses = p;
        n.scan = s;
        {n.irq, n.rst, n.runAfter} = ir;
        return n;
    endfunction : mk

    task automatic do_cmd(input logic [17:0] a, input logic we, input hicc_note_t n);
        bit ok;
        noteQ.push_back(n);
        hostU.access(a, we, ok);
        check("handshake", 64'h1, {63'h0, ok});
    endtask : do_cmd

    task automatic end_sim();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    // ----------------------------------------------------------------
    // Monitor: gathers what the controller did during each transaction
    // ----------------------------------------------------------------
    // Outputs are registered, so sampling at the edge sees settled values.
    always @(posedge sys_clk) begin
        if (reset_n === 1'b1) begin
            acc.rd |= memRead;
            acc.wr |= memWrite;
            acc.prd |= portRead;
            acc.pwr |= portWrite;
            if (memRead === 1'b1 || memWrite === 1'b1) acc.addr = memory_address_bus;
            acc.clk |= clkPulse;
            if (clkPulse !== '0) acc.pulses++;
            acc.scan |= shadow_scan_chain;
            if (shadow_scan_chain.storeShift === 1'b1 || shadow_scan_chain.macroShift === 1'b1)
                acc.shifts++;
            if (portShiftLoad === 1'b1) begin
                acc.loads++;
                check("serial", 64'(img[0]), 64'(chainSerialIn));
                img = {shadow_scan_chain.macroShift ? lastM : lastS, img[PORT_W-1:1]};
                check("image", 64'(img), 64'(portShiftData));
            end
            acc.irq |= cpuIrqReq;
            acc.rst |= cpuReset;
            if (shadow_scan_chain.storeShift === 1'b1) check("run", 64'h0, {63'h0, cpuRun});
            if (postChk) check("release", {61'h0, 2'b01, exp.runAfter}, {extXcvrEn, cpuDriveEn, cpuRun});
            postChk = 1'b0;
            if (host_wait_release === 1'b1 && readyPrev !== 1'b1) begin
                exp = (noteQ.size() > 0) ? noteQ.pop_front() : '1;
                acc.clk &= exp.clkMask;
                acc.runAfter = exp.runAfter;
                acc.clkMask = exp.clkMask;
                if (exp.clkMask == 5'h00) acc.pulses = exp.pulses;
                check("actions", exp, acc);
                check("hold", 64'h4, {extXcvrEn, cpuDriveEn, cpuRun});
            end else if (host_wait_release !== 1'b1 && readyPrev === 1'b1) begin
                acc = '0;
                postChk = 1'b1;
            end
        end
        readyPrev = host_wait_release;
        lastS = storeChainOut;
        lastM = macroChainOut;
    end

    // Returning serial bits change every cycle from the pseudo random stream.
    always @(posedge sys_clk) begin
        #5;
        seed = xs(seed);
        storeChainOut = seed[0];
        macroChainOut = seed[1];
    end

    // ----------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------
    initial begin
        hicc_note_t n;
        logic [3:0] nib;
        repeat (2) @(posedge sys_clk);
        #5;
        reset_n = 1'b1;
        for (int i = 0; i < 8; i++) begin
            n = mk(5'h0, 5'h1F, 8'h0, 6'h0, 3'b001);
            n.addr = (i < 4) ? seed[31:16] : 16'h0;
            {n.rd, n.wr} = (i < 4) ? {~seed[5], seed[5]} : 2'b00;
            {n.prd, n.pwr} = (i < 4) ? 2'b00 : {~seed[5], seed[5]};
            do_cmd({1'b0, i >= 4, seed[31:16]}, seed[5], n);
        end
        do_cmd(18'h20001, 1'b0, mk(5'h00, 5'h1F, 8'h0, 6'h00, 3'b000));
        n = mk(5'h00, 5'h1F, 8'h0, 6'h00, 3'b000);
        {n.addr, n.rd} = {seed[31:16], 1'b1};
        do_cmd({2'b00, seed[31:16]}, 1'b0, n);
        do_cmd(18'h20003, 1'b0, mk(5'h1F, 5'h1F, 8'h1, 6'h00, 3'b000));
        do_cmd(18'h20004, 1'b0, mk(5'h1C, 5'h1F, 8'h1, 6'h00, 3'b000));
        do_cmd(18'h20005, 1'b0, mk(5'h02, 5'h1F, 8'h1, 6'h00, 3'b000));
        do_cmd(18'h20006, 1'b0, mk(5'h00, 5'h1F, 8'h0, 6'h00, 3'b100));
        do_cmd(18'h30001, 1'b0, mk(5'h10, 5'h1F, 8'h1, 6'h20, 3'b000));
        do_cmd(18'h30002, 1'b0, mk(5'h08, 5'h1F, 8'h1, 6'h20, 3'b000));
        do_cmd(18'h30003, 1'b0, mk(5'h00, 5'h1F, 8'h0, 6'h02, 3'b000));
        do_cmd(18'h30004, 1'b0, mk(5'h00, 5'h1F, 8'h0, 6'h01, 3'b000));
        do_cmd(18'h30005, 1'b0, mk(5'h00, 5'h1F, 8'h0, 6'h10, 3'b000));
        for (int i = 0; i < 4; i++) begin
            nib = (i == 0) ? 4'h0 : seed[9:6];
            n = mk(5'h00, 5'h1F, 8'h0, i[0] ? 6'h04 : 6'h08, 3'b000);
            n.shifts = (nib == 4'h0) ? 8'h40 : {2'b00, nib, 2'b00};
            n.loads = n.shifts;
            do_cmd({2'b11, 9'h0, nib, 2'b11, i[0]}, 1'b0, n);
        end
        do_cmd(18'h20002, 1'b0, mk(5'h00, 5'h1F, 8'h0, 6'h00, 3'b001));
        do_cmd(18'h20007, 1'b0, mk(5'h1E, 5'h1F, 8'h1, 6'h00, 3'b011));
        repeat (4) @(posedge sys_clk);
        check("pending", 64'h0, 64'(noteQ.size()));
        end_sim();
    end

    // Watchdog well beyond the longest expected run.
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        end_sim();
    end
endmodule : hicc_controller_test

// File: hicc_host_model.sv
// Host bus master model that runs one select and ready transaction at a time.
`timescale 1ns/10ps
module hicc_host_model
    import hicc_pkg::*;
(
    input wire logic sys_clk,                 // System clock, used for pacing only.
    input wire logic hostReady,               // Ready from the controller.
    output logic hostSelect,                  // Selects the system.
    output logic [HOST_ADDR_W-1:0] hostAddr,  // Address on the external bus.
    output logic hostWriteEn                  // High for a write.
);
    initial begin
        hostSelect = 1'b0;
        hostAddr = '0;
        hostWriteEn = 1'b0;
    end

    // ----------------------------------------------------------------
    // Transaction
    // ----------------------------------------------------------------
    // Address and direction stay stable until ready is seen, then the bus is released.
    // A released bus shows the inverted address so stale values never look valid.
    task automatic access(input logic [HOST_ADDR_W-1:0] addr, input logic we, output bit ok);
        int n;
        n = 0;
        @(posedge sys_clk);
        #5;
        hostAddr = addr;
        hostWriteEn = we;
        hostSelect = 1'b1;
        while (hostReady !== 1'b1 && n < 3000) begin
            @(posedge sys_clk);
            n++;
        end
        #5;
        hostSelect = 1'b0;
        hostAddr = ~addr;
        hostWriteEn = ~we;
        while (hostReady !== 1'b0 && n < 3100) begin
            @(posedge sys_clk);
            n++;
        end
        ok = (n < 3000);
    endtask : access
endmodule : hicc_host_model

// File: hicc_pkg.sv
// Package with codes, states, timing constants and carrier types for the host command controller.
package hicc_pkg;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    localparam int HOST_ADDR_W = 18;
    localparam int SEL_HI_BIT = 17;
    localparam int SEL_LO_BIT = 16;
    localparam int MEM_ADDR_W = 16;
    localparam int NIB_CNT_LSB = 3;
    localparam int NIB_CNT_W = 4;
    localparam int PORT_W = 32;

    localparam logic [1:0] SPACE_MEM = 2'h0;
    localparam logic [1:0] SPACE_PORT = 2'h1;
    localparam logic [1:0] SPACE_RUNCTL = 2'h2;
    localparam logic [1:0] SPACE_SCAN = 2'h3;

    localparam logic [2:0] OP_ILLEGAL = 3'h0;
    localparam logic [2:0] OP_HALT = 3'h1;
    localparam logic [2:0] OP_RUN = 3'h2;
    localparam logic [2:0] OP_STEP_ALL = 3'h3;
    localparam logic [2:0] OP_STEP_CTRL = 3'h4;
    localparam logic [2:0] OP_STEP_DATA = 3'h5;
    localparam logic [2:0] OP_INTERRUPT = 3'h6;
    localparam logic [2:0] OP_RESET = 3'h7;
    localparam logic [2:0] OP_LOAD_PIPE = 3'h1;
    localparam logic [2:0] OP_LOAD_MACRO = 3'h2;
    localparam logic [2:0] OP_LOAD_STORE = 3'h3;
    localparam logic [2:0] OP_LOAD_INIT = 3'h4;
    localparam logic [2:0] OP_CAPTURE = 3'h5;
    localparam logic [2:0] OP_SHIFT_STORE = 3'h6;
    localparam logic [2:0] OP_SHIFT_MACRO = 3'h7;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int STORE_GAP_NS = 65;
    localparam int STORE_GAP_CYC = (STORE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_CYC = 2;
    localparam int STORE_WRITE_CYC = 3;
    localparam logic [3:0] ACCESS_CNT = 4'(ACCESS_CYC);
    localparam logic [3:0] STORE_WRITE_CNT = 4'(STORE_WRITE_CYC);
    localparam logic [3:0] GAP_CNT = 4'(STORE_GAP_CYC);
    localparam int BITS_PER_NIB = 4;
    localparam logic [6:0] NIB_BITS = 7'h04;

    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_DECODE = 7'h02,
        ST_ACCESS = 7'h04,
        ST_PULSE = 7'h08,
        ST_SHIFT = 7'h10,
        ST_DONE = 7'h20,
        ST_TRAP = 7'h40
    } hicc_state_t;

    // Clock enables towards the CPU clock groups.
    typedef struct packed {
        logic ctrlPipe;   // Control pipeline and store port.
        logic macro;      // Macro opcode, operand, status, interrupt base.
        logic sequencer;  // Sequencer and interrupt registers.
        logic dataSect;   // Data section.
        logic gatedOk;    // Gated clocks may follow their own enables.
    } hicc_clk_t;

    // Shadow chain controls.
    typedef struct packed {
        logic parallelLoad; // Registers load from the chain.
        logic capture;      // Chain copies from registers.
        logic storeShift;   // Store chain shift clock.
        logic macroShift;   // Macro chain shift clock.
        logic storeWrite;   // Write store and opcode map.
        logic initLoad;     // Load store initialise registers.
    } hicc_scan_t;

endpackage : hicc_pkg
